// ===== inc/pin_mux_consts.svh
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_USB_CTRL_STAT 8'h00
`define OFS_PB_ALT_SEL 8'h04
`define OFS_PC_ALT_SEL 8'h08
`define OFS_PC_WAVE_SEL 8'h0c
`define OFS_IFACE_CFG 8'h10
`define OFS_IRQ_EDGE_SEL 8'h14
`define OFS_PB_OUT_DATA 8'h18
`define OFS_PB_DIR 8'h1c
`define OFS_PC_OUT_DATA 8'h20
`define OFS_PC_DIR 8'h24
`define OFS_PIN_STATE 8'h28

// ==========================================================================
// Field positions
`define USB_ATTACH_OE_BIT 2
`define USB_ATTACH_LVL_BIT 3
`define PIN_STATE_PC_LSB 5
`define IRQ0_EDGE_BIT 0
`define IRQ1_EDGE_BIT 1

// ==========================================================================
// Reset values
`define RST_USB_CTRL_STAT 4'h0
`define RST_PB_ALT 5'h00
`define RST_PC_ALT 4'h0
`define RST_PC_WAVE 4'h0
`define RST_IFACE_CFG 2'h0
`define RST_IRQ_EDGE 2'h0
`define RST_PB_DATA 5'h00
`define RST_PC_DATA 4'h0

`endif

// ===== inc/pin_mux_pkg.sv
package pin_mux_pkg;

  typedef enum logic [2:0] {
    FN_GPIO = 3'h0,
    FN_CORE = 3'h1,
    FN_MEM = 3'h2,
    FN_WAVE = 3'h3,
    FN_FIFO = 3'h4
  } pin_func_t;

endpackage

// ===== inc/irq_det_if.sv
`timescale 1ns/1ps

interface irq_det_if;
  logic level;
  logic enable;
  logic edge_mode;
  logic active_low;
  logic req;

  modport det (
    input level,
    input enable,
    input edge_mode,
    input active_low,
    output req
  );

  modport user (
    output level,
    output enable,
    output edge_mode,
    output active_low,
    input req
  );
endinterface

// ===== hw/irq_sense.sv
`timescale 1ns/1ps

module irq_sense (
  input wire logic clk,
  input wire logic rst,
  irq_det_if.det port
);

  logic active;
  logic prev_active_r;
  logic req_r;

  assign active = port.level ^ port.active_low;

  // Start as if already asserted so a pin sitting active at release
  // does not look like a fresh edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_active_r <= 1'b1;
    else
      prev_active_r <= active;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      req_r <= 1'b0;
    else if (port.edge_mode)
      req_r <= port.enable & active & ~prev_active_r;
    else
      req_r <= port.enable & active;
  end

  assign port.req = req_r;

endmodule // irq_sense

// ===== hw/usb_micro_port_pin_mux.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "pin_mux_consts.svh"


module usb_micro_port_pin_mux #(
  parameter logic ALT_ON = 1'b1,
  parameter logic WAVE_ON = 1'b1,
  parameter logic [1:0] IFCFG_MEM = 2'h1,
  parameter logic [1:0] IFCFG_WAVE = 2'h2,
  parameter logic [1:0] IFCFG_FIFO = 2'h3
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic USB_ATTACH_PULLUP_OUT,
  output logic USB_ATTACH_PULLUP_OE,
  input wire logic [4:0] PB_IN,
  output logic [4:0] PB_OUT,
  output logic [4:0] PB_OE,
  input wire logic [3:0] PC_IN,
  output logic [3:0] PC_OUT,
  output logic [3:0] PC_OE,
  input wire logic SERIAL1_TX,
  input wire logic SERIAL0_TX,
  output logic SERIAL0_RX,
  input wire logic TIMER2_OVERFLOW,
  input wire logic [4:0] FIFO_A_WR_DATA,
  input wire logic FIFO_A_DRIVE,
  output logic [4:0] FIFO_A_RD_DATA,
  input wire logic [4:0] WAVEFORM_DATA_A_WR,
  input wire logic WAVEFORM_DATA_A_DRIVE,
  output logic [4:0] WAVEFORM_DATA_A_RD,
  input wire logic [4:0] MEM_DATA_WR,
  input wire logic MEM_DATA_DRIVE,
  output logic [4:0] MEM_DATA_RD,
  output logic [2:0] WAVEFORM_READY,
  output logic EXT_IRQ4_REQ,
  output logic EXT_IRQ5_REQ,
  output logic EXT_IRQ6_REQ,
  output logic EXT_IRQ0_REQ,
  output logic EXT_IRQ1_REQ,
  output logic [8:0] PIN_STATE_FAST
);

  // Two equal codes would make one bus mode unreachable
  if (IFCFG_MEM == IFCFG_WAVE || IFCFG_MEM == IFCFG_FIFO || IFCFG_WAVE == IFCFG_FIFO)
  begin : g_cfg_check
    $error("Interface config codes must differ");
  end

  // ==========================================================================
  // Registers
  logic usb_oe_r;
  logic usb_lvl_r;
  logic [4:0] pb_alt_r;
  logic [3:0] pc_alt_r;
  logic [3:0] pc_wave_r;
  logic [1:0] ifcfg_r;
  logic [1:0] irq_edge_r;
  logic [4:0] pb_data_r;
  logic [4:0] pb_dir_r;
  logic [3:0] pc_data_r;
  logic [3:0] pc_dir_r;
  logic [31:0] rdata_nxt;
  logic [31:0] prdata_r;
  logic addr_ok;
  logic wr_en;
  logic [8:0] pin_meta_r;
  logic [8:0] pin_sync_r;
  logic [4:0] pb_s;
  logic [3:0] pc_s;

  assign wr_en = PSEL & PENABLE & PWRITE;

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      usb_oe_r <= 1'b0;
      usb_lvl_r <= 1'b0;
      pb_alt_r <= `RST_PB_ALT;
      pc_alt_r <= `RST_PC_ALT;
      pc_wave_r <= `RST_PC_WAVE;
      ifcfg_r <= `RST_IFACE_CFG;
      irq_edge_r <= `RST_IRQ_EDGE;
      pb_data_r <= `RST_PB_DATA;
      pb_dir_r <= `RST_PB_DATA;
      pc_data_r <= `RST_PC_DATA;
      pc_dir_r <= `RST_PC_DATA;
    end
    else if (wr_en)
    begin
      unique case (PADDR)
        `OFS_USB_CTRL_STAT:
        begin
          usb_oe_r <= PWDATA[`USB_ATTACH_OE_BIT];
          usb_lvl_r <= PWDATA[`USB_ATTACH_LVL_BIT];
        end
        `OFS_PB_ALT_SEL: pb_alt_r <= PWDATA[4:0];
        `OFS_PC_ALT_SEL: pc_alt_r <= PWDATA[3:0];
        `OFS_PC_WAVE_SEL: pc_wave_r <= {PWDATA[3], 1'b0, PWDATA[1:0]};
        `OFS_IFACE_CFG: ifcfg_r <= PWDATA[1:0];
        `OFS_IRQ_EDGE_SEL: irq_edge_r <= PWDATA[1:0];
        `OFS_PB_OUT_DATA: pb_data_r <= PWDATA[4:0];
        `OFS_PB_DIR: pb_dir_r <= PWDATA[4:0];
        `OFS_PC_OUT_DATA: pc_data_r <= PWDATA[3:0];
        `OFS_PC_DIR: pc_dir_r <= PWDATA[3:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    addr_ok = 1'b1;
    rdata_nxt = 32'h0;
    unique case (PADDR)
      `OFS_USB_CTRL_STAT:
      begin
        rdata_nxt[`USB_ATTACH_OE_BIT] = usb_oe_r;
        rdata_nxt[`USB_ATTACH_LVL_BIT] = usb_lvl_r;
      end
      `OFS_PB_ALT_SEL: rdata_nxt[4:0] = pb_alt_r;
      `OFS_PC_ALT_SEL: rdata_nxt[3:0] = pc_alt_r;
      `OFS_PC_WAVE_SEL: rdata_nxt[3:0] = pc_wave_r;
      `OFS_IFACE_CFG: rdata_nxt[1:0] = ifcfg_r;
      `OFS_IRQ_EDGE_SEL: rdata_nxt[1:0] = irq_edge_r;
      `OFS_PB_OUT_DATA: rdata_nxt[4:0] = pb_data_r;
      `OFS_PB_DIR: rdata_nxt[4:0] = pb_dir_r;
      `OFS_PC_OUT_DATA: rdata_nxt[3:0] = pc_data_r;
      `OFS_PC_DIR: rdata_nxt[3:0] = pc_dir_r;
      `OFS_PIN_STATE: rdata_nxt[8:0] = pin_sync_r;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      prdata_r <= 32'h0;
    else if (PSEL & ~PENABLE & ~PWRITE)
      prdata_r <= rdata_nxt;
  end

  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  // ==========================================================================
  // USB attach pull-up
  assign USB_ATTACH_PULLUP_OE = usb_oe_r;
  assign USB_ATTACH_PULLUP_OUT = ~usb_lvl_r;

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_meta_r <= 9'h000;
      pin_sync_r <= 9'h000;
    end
    else
    begin
      pin_meta_r <= {PC_IN, PB_IN};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign pb_s = pin_sync_r[4:0];
  assign pc_s = pin_sync_r[8:5];
  // Fast view for the core's bit access; same sampling as the register
  assign PIN_STATE_FAST = pin_sync_r;

  // ==========================================================================
  // Function decode
  function automatic pin_mux_pkg::pin_func_t pb_func(input logic alt, input logic [1:0] cfg);
    pin_mux_pkg::pin_func_t f;
    f = pin_mux_pkg::FN_GPIO;
    if (cfg == IFCFG_FIFO)
      f = pin_mux_pkg::FN_FIFO;
    else if (cfg == IFCFG_WAVE)
      f = pin_mux_pkg::FN_WAVE;
    else if (alt == ALT_ON)
      f = pin_mux_pkg::FN_CORE;
    else if (cfg == IFCFG_MEM)
      f = pin_mux_pkg::FN_MEM;
    return f;
  endfunction

  function automatic pin_mux_pkg::pin_func_t pc_func(input logic alt, input logic wave);
    pin_mux_pkg::pin_func_t f;
    f = pin_mux_pkg::FN_GPIO;
    if (wave == WAVE_ON)
      f = pin_mux_pkg::FN_WAVE;
    else if (alt == ALT_ON)
      f = pin_mux_pkg::FN_CORE;
    return f;
  endfunction

  pin_mux_pkg::pin_func_t pb_fn [5];
  pin_mux_pkg::pin_func_t pc_fn [4];

  always_comb
  begin
    for (int i = 0; i < 5; i++)
      pb_fn[i] = pb_func(pb_alt_r[i], ifcfg_r);
    for (int j = 0; j < 4; j++)
      pc_fn[j] = pc_func(pc_alt_r[j], pc_wave_r[j]);
  end

  // ==========================================================================
  // Port B drive; core-side outputs per bit: 3 serial, 7 timer, rest inputs
  logic [4:0] pb_core_out;
  logic [4:0] pb_core_oe;
  assign pb_core_out = {TIMER2_OVERFLOW, 3'h0, SERIAL1_TX};
  assign pb_core_oe = 5'h11;

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PB_OUT <= 5'h00;
      PB_OE <= 5'h00;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        unique case (pb_fn[i])
          pin_mux_pkg::FN_CORE:
          begin
            PB_OUT[i] <= pb_core_out[i];
            PB_OE[i] <= pb_core_oe[i];
          end
          pin_mux_pkg::FN_FIFO:
          begin
            PB_OUT[i] <= FIFO_A_WR_DATA[i];
            PB_OE[i] <= FIFO_A_DRIVE;
          end
          pin_mux_pkg::FN_WAVE:
          begin
            PB_OUT[i] <= WAVEFORM_DATA_A_WR[i];
            PB_OE[i] <= WAVEFORM_DATA_A_DRIVE;
          end
          pin_mux_pkg::FN_MEM:
          begin
            PB_OUT[i] <= MEM_DATA_WR[i];
            PB_OE[i] <= MEM_DATA_DRIVE;
          end
          default:
          begin
            PB_OUT[i] <= pb_data_r[i];
            PB_OE[i] <= pb_dir_r[i];
          end
        endcase
      end
    end
  end

  // Inbound data buses follow the pins only in their own mode
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      FIFO_A_RD_DATA[i] = (pb_fn[i] == pin_mux_pkg::FN_FIFO) & pb_s[i];
      WAVEFORM_DATA_A_RD[i] = (pb_fn[i] == pin_mux_pkg::FN_WAVE) & pb_s[i];
      MEM_DATA_RD[i] = (pb_fn[i] == pin_mux_pkg::FN_MEM) & pb_s[i];
    end
  end

  // ==========================================================================
  // Port C drive; only bit 1 has a core output
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PC_OUT <= 4'h0;
      PC_OE <= 4'h0;
    end
    else
    begin
      for (int j = 0; j < 4; j++)
      begin
        if (pc_fn[j] == pin_mux_pkg::FN_GPIO)
        begin
          PC_OUT[j] <= pc_data_r[j];
          PC_OE[j] <= pc_dir_r[j];
        end
        else if (j == 1 && pc_fn[j] == pin_mux_pkg::FN_CORE)
        begin
          PC_OUT[j] <= SERIAL0_TX;
          PC_OE[j] <= 1'b1;
        end
        else
        begin
          PC_OUT[j] <= 1'b0;
          PC_OE[j] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      SERIAL0_RX <= 1'b1;
    else if (pc_fn[0] == pin_mux_pkg::FN_CORE)
      SERIAL0_RX <= pc_s[0];
    else
      SERIAL0_RX <= 1'b1;
  end

  assign WAVEFORM_READY = {pc_s[3] & (pc_fn[3] == pin_mux_pkg::FN_WAVE),
                           pc_s[1] & (pc_fn[1] == pin_mux_pkg::FN_WAVE),
                           pc_s[0] & (pc_fn[0] == pin_mux_pkg::FN_WAVE)};

  // ==========================================================================
  // Interrupt inputs: 4, 5, 6 on port B; 0, 1 on port C
  irq_det_if irq_if [5] ();
  logic [4:0] irq_lvl;
  logic [4:0] irq_en;
  logic [4:0] irq_edge;
  logic [4:0] irq_low;
  logic [4:0] irq_req;

  assign irq_lvl = {pc_s[3], pc_s[2], pb_s[3], pb_s[2], pb_s[1]};
  assign irq_en = {pc_fn[3] == pin_mux_pkg::FN_CORE, pc_fn[2] == pin_mux_pkg::FN_CORE,
                   pb_fn[3] == pin_mux_pkg::FN_CORE, pb_fn[2] == pin_mux_pkg::FN_CORE,
                   pb_fn[1] == pin_mux_pkg::FN_CORE};
  assign irq_edge = {irq_edge_r[`IRQ1_EDGE_BIT], irq_edge_r[`IRQ0_EDGE_BIT], 3'h7};
  assign irq_low = 5'h1a;

  for (genvar k = 0; k < 5; k++)
  begin : g_irq
    assign irq_if[k].level = irq_lvl[k];
    assign irq_if[k].enable = irq_en[k];
    assign irq_if[k].edge_mode = irq_edge[k];
    assign irq_if[k].active_low = irq_low[k];
    assign irq_req[k] = irq_if[k].req;
    irq_sense u_sense (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .port(irq_if[k])
    );
  end

  assign EXT_IRQ4_REQ = irq_req[0];
  assign EXT_IRQ5_REQ = irq_req[1];
  assign EXT_IRQ6_REQ = irq_req[2];
  assign EXT_IRQ0_REQ = irq_req[3];
  assign EXT_IRQ1_REQ = irq_req[4];

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  a_pullup_float: assert property (wr_en && PADDR == `OFS_USB_CTRL_STAT && !PWDATA[2]
    |=> !USB_ATTACH_PULLUP_OE) else $error("Pull-up not floated");
  a_pullup_attach: assert property (wr_en && PADDR == `OFS_USB_CTRL_STAT && PWDATA[2] && !PWDATA[3]
    |=> USB_ATTACH_PULLUP_OE && USB_ATTACH_PULLUP_OUT) else $error("Attach level wrong");
  a_fifo_drive: assert property (pb_fn[2] == pin_mux_pkg::FN_FIFO && FIFO_A_DRIVE
    |=> PB_OE[2] && PB_OUT[2] == $past(FIFO_A_WR_DATA[2])) else $error("FIFO drive bad");
  a_serial1_tx: assert property (pb_fn[0] == pin_mux_pkg::FN_CORE
    |=> PB_OE[0] && PB_OUT[0] == $past(SERIAL1_TX)) else $error("Serial 1 tx bad");
  a_serial0_tx: assert property (pc_fn[1] == pin_mux_pkg::FN_CORE
    |=> PC_OE[1] && PC_OUT[1] == $past(SERIAL0_TX)) else $error("Serial 0 tx bad");
  a_serial0_rx: assert property (pc_fn[0] == pin_mux_pkg::FN_CORE
    |=> SERIAL0_RX == $past(PC_IN[0], 3)) else $error("Serial 0 rx bad");
  a_irq4_rise: assert property (irq_en[0] && $rose(pb_s[1])
    |=> EXT_IRQ4_REQ ##1 !EXT_IRQ4_REQ) else $error("Irq 4 edge missed");
  a_irq5_fall: assert property (irq_en[1] && $fell(pb_s[2])
    |=> EXT_IRQ5_REQ ##1 !EXT_IRQ5_REQ) else $error("Irq 5 edge missed");
  a_irq6_rise: assert property (irq_en[2] && $rose(pb_s[3])
    |=> EXT_IRQ6_REQ) else $error("Irq 6 edge missed");
  a_timer2_pulse: assert property (pb_fn[4] == pin_mux_pkg::FN_CORE && TIMER2_OVERFLOW
    ##1 !TIMER2_OVERFLOW |-> PB_OUT[4] ##1 !PB_OUT[4]) else $error("Timer pulse bad");
  a_irq0_level: assert property (irq_en[3] && !irq_edge_r[0] && !pc_s[2]
    |=> EXT_IRQ0_REQ) else $error("Irq 0 level missed");
  a_irq1_edge: assert property (irq_en[4] && irq_edge_r[1] && !EXT_IRQ1_REQ
    ##1 EXT_IRQ1_REQ |-> $past(pc_s[3], 2) && !$past(pc_s[3])) else $error("Irq 1 edge bad");
  a_pc2_no_wave: assert property (pc_fn[2] != pin_mux_pkg::FN_WAVE && !PC_OE[2]
    || pc_fn[2] == pin_mux_pkg::FN_GPIO || $past(pc_fn[2]) == pin_mux_pkg::FN_GPIO)
    else $error("Port C 2 bad function");
  a_reset_inputs: assert property (disable iff (1'b0) SYS_RST |=> PB_OE == 5'h00 && PC_OE == 4'h0
    && !USB_ATTACH_PULLUP_OE) else $error("Pins driven in reset");

  c_attach: cover property (USB_ATTACH_PULLUP_OE && USB_ATTACH_PULLUP_OUT);
  c_irq4: cover property (EXT_IRQ4_REQ);
  c_fifo_mode: cover property (pb_fn[0] == pin_mux_pkg::FN_FIFO && FIFO_A_DRIVE);
  c_irq0_level: cover property (EXT_IRQ0_REQ [*3]);

endmodule // usb_micro_port_pin_mux

// ===== tb/pin_board_model.sv
`timescale 1ns/1ps

// ==========================================================
// Board around the port pins: pull-ups, external drivers, host
module pin_board_model (
  input wire logic [4:0] pb_drv,
  input wire logic [4:0] pb_oe,
  input wire logic [3:0] pc_drv,
  input wire logic [3:0] pc_oe,
  input wire logic [4:0] pb_ext,
  input wire logic [4:0] pb_ext_en,
  input wire logic [3:0] pc_ext,
  input wire logic [3:0] pc_ext_en,
  input wire logic attach_out,
  input wire logic attach_oe,
  output logic [4:0] pb_pin,
  output logic [3:0] pc_pin,
  output logic host_attached
);
  // Released pins follow an enabled external driver, else go to the pull-up level, never keep a stale value
  assign pb_pin = (pb_oe & pb_drv) | (~pb_oe & (~pb_ext_en | pb_ext));
  assign pc_pin = (pc_oe & pc_drv) | (~pc_oe & (~pc_ext_en | pc_ext));
  // The host sees the device only while the pull-up is driven high
  assign host_attached = attach_oe & attach_out;
endmodule // pin_board_model

// ===== tb/tb_usb_micro_port_pin_mux.sv
`timescale 1ns/1ps
`include "pin_mux_consts.svh"

module tb_usb_micro_port_pin_mux;
  logic sys_clk, sys_rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic s1_tx, s0_tx, t2_ovf, fifo_drv, wave_drv, mem_drv, err;
  logic [4:0] fifo_wr, wave_wr, mem_wr, pb_ext, pb_ext_en;
  logic [3:0] pc_ext, pc_ext_en;
  wire [31:0] prdata;
  wire pready, pslverr, att_out, att_oe, s0_rx, attached;
  wire [4:0] pb_in, pb_out, pb_oe, fifo_rd, wave_rd, mem_rd;
  wire [3:0] pc_in, pc_out, pc_oe;
  wire [2:0] wave_rdy;
  wire [8:0] pin_fast;
  wire i4, i5, i6, i0, i1;
  wire [5:0] evt = {pb_out[4], i1, i0, i6, i5, i4};
  int miscompares, n_checks, cnt;

  usb_micro_port_pin_mux u_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .USB_ATTACH_PULLUP_OUT(att_out),
    .USB_ATTACH_PULLUP_OE(att_oe), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
    .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe), .SERIAL1_TX(s1_tx), .SERIAL0_TX(s0_tx),
    .SERIAL0_RX(s0_rx), .TIMER2_OVERFLOW(t2_ovf), .FIFO_A_WR_DATA(fifo_wr),
    .FIFO_A_DRIVE(fifo_drv), .FIFO_A_RD_DATA(fifo_rd), .WAVEFORM_DATA_A_WR(wave_wr),
    .WAVEFORM_DATA_A_DRIVE(wave_drv), .WAVEFORM_DATA_A_RD(wave_rd), .MEM_DATA_WR(mem_wr),
    .MEM_DATA_DRIVE(mem_drv), .MEM_DATA_RD(mem_rd), .WAVEFORM_READY(wave_rdy),
    .EXT_IRQ4_REQ(i4), .EXT_IRQ5_REQ(i5), .EXT_IRQ6_REQ(i6), .EXT_IRQ0_REQ(i0),
    .EXT_IRQ1_REQ(i1), .PIN_STATE_FAST(pin_fast));

  pin_board_model u_board (.pb_drv(pb_out), .pb_oe(pb_oe), .pc_drv(pc_out), .pc_oe(pc_oe),
    .pb_ext(pb_ext), .pb_ext_en(pb_ext_en), .pc_ext(pc_ext), .pc_ext_en(pc_ext_en),
    .attach_out(att_out), .attach_oe(att_oe), .pb_pin(pb_in), .pc_pin(pc_in),
    .host_attached(attached));

  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      miscompares++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check({err, rd}, {1'b0, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Counts cycles in which one watched output is high, starting now
  task automatic count_high(input int idx, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      #1;
      if (evt[idx] === 1'b1)
        c++;
      @(posedge sys_clk);
    end
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {s1_tx, s0_tx, t2_ovf, fifo_drv, wave_drv, mem_drv} = 6'h0;
    {fifo_wr, wave_wr, mem_wr, pb_ext, pb_ext_en, pc_ext, pc_ext_en} = 33'h0;
    step(8);
    sys_rst <= 1'b0;
    #1;
    check({pb_oe, pc_oe, s0_rx, att_oe, att_out, evt}, {9'h0, 3'b101, 6'h0});
    for (int a = 0; a <= 8'h24; a += 4)
      rchk(a[7:0], 32'h0);
    rchk(`OFS_PIN_STATE, 32'h1ff);
    apb(1'b0, 8'hfc, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    // Attach pull-up: drive high, drive low, float
    apb(1'b1, `OFS_USB_CTRL_STAT, 32'h4);
    step(2);
    #1;
    check({att_oe, att_out, attached}, 3'b111);
    apb(1'b1, `OFS_USB_CTRL_STAT, 32'hc);
    step(2);
    #1;
    check({att_oe, att_out, attached}, 3'b100);
    apb(1'b1, `OFS_USB_CTRL_STAT, 32'h8);
    step(2);
    #1;
    check({att_oe, attached}, 2'b00);
    // Serial functions on PB3, PC1 and PC0
    apb(1'b1, `OFS_PB_ALT_SEL, 32'h1);
    apb(1'b1, `OFS_PC_ALT_SEL, 32'h3);
    for (int v = 1; v >= 0; v--)
    begin
      step(1);
      s1_tx <= v[0];
      s0_tx <= v[0];
      pc_ext_en[0] <= 1'b1;
      pc_ext[0] <= ~v[0];
      step(5);
      #1;
      check({pb_oe[0], pb_out[0], pc_oe[1], pc_out[1]}, {1'b1, v[0], 1'b1, v[0]});
      check({pc_oe[0], s0_rx}, {1'b0, ~v[0]});
    end
    // Edge interrupts on PB4..PB6 and the timer pulse on PB7
    apb(1'b1, `OFS_PB_ALT_SEL, 32'h1f);
    for (int b = 1; b < 4; b++)
      for (int v = 0; v < 2; v++)
      begin
        step(1);
        pb_ext_en[b] <= 1'b1;
        pb_ext[b] <= v[0];
        count_high(b - 1, 8, cnt);
        check(cnt, (v == (b == 2 ? 0 : 1)) ? 1 : 0);
      end
    step(1);
    t2_ovf <= 1'b1;
    step(1);
    t2_ovf <= 1'b0;
    count_high(5, 8, cnt);
    check({cnt, pb_oe[4]}, {32'd1, 1'b1});
    // Interrupt 0 and 1: level mode, then edge mode
    apb(1'b1, `OFS_PC_ALT_SEL, 32'hf);
    pc_ext_en[3:2] <= 2'b11;
    pc_ext[3:2] <= 2'b11;
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `OFS_IRQ_EDGE_SEL, m ? 32'h3 : 32'h0);
      for (int i = 0; i < 2; i++)
      begin
        step(4);
        pc_ext[2 + i] <= 1'b0;
        count_high(3 + i, 8, cnt);
        #1;
        if (m == 1)
          check(cnt, 1);
        else
          check(evt[3 + i], 1'b1);
        pc_ext[2 + i] <= 1'b1;
        step(6);
        #1;
        check(evt[3 + i], 1'b0);
      end
    end
    // Port B bus modes: memory, waveform, FIFO
    apb(1'b1, `OFS_PC_ALT_SEL, 32'h0);
    apb(1'b1, `OFS_PB_ALT_SEL, 32'h0);
    pb_ext_en <= 5'h0;
    {fifo_wr, wave_wr, mem_wr} <= {5'h15, 5'h0a, 5'h13};
    {fifo_drv, wave_drv, mem_drv} <= 3'b111;
    for (int c = 1; c < 4; c++)
    begin
      apb(1'b1, `OFS_IFACE_CFG, c);
      step(3);
      #1;
      check({pb_oe, pb_out}, {5'h1f, c == 3 ? 5'h15 : c == 2 ? 5'h0a : 5'h13});
      step(1);
      {fifo_drv, wave_drv, mem_drv} <= 3'b000;
      pb_ext_en <= 5'h1f;
      pb_ext <= 5'h0c + c[4:0];
      step(4);
      #1;
      check({pb_oe, fifo_rd, wave_rd, mem_rd}, {5'h0, (15'h0c + c) << (5 * (c - 1))});
      step(1);
      pb_ext_en <= 5'h0;
      {fifo_drv, wave_drv, mem_drv} <= 3'b111;
    end
    apb(1'b1, `OFS_IFACE_CFG, 32'h0);
    // GPIO outputs on both ports, seen back through the pin state
    apb(1'b1, `OFS_PB_OUT_DATA, 32'h16);
    apb(1'b1, `OFS_PB_DIR, 32'h1f);
    apb(1'b1, `OFS_PC_OUT_DATA, 32'h6);
    apb(1'b1, `OFS_PC_DIR, 32'hf);
    step(3);
    #1;
    check({pb_oe, pb_out, pc_oe, pc_out}, {5'h1f, 5'h16, 4'hf, 4'h6});
    rchk(`OFS_PIN_STATE, 32'h0d6);
    apb(1'b1, `OFS_PB_DIR, 32'h0);
    apb(1'b1, `OFS_PC_DIR, 32'h0);
    // Waveform ready inputs and pin state
    apb(1'b1, `OFS_PC_WAVE_SEL, 32'hf);
    rchk(`OFS_PC_WAVE_SEL, 32'hb);
    pc_ext_en <= 4'hf;
    pc_ext <= 4'b1001;
    pb_ext_en <= 5'h1f;
    pb_ext <= 5'h0d;
    step(4);
    #1;
    check({pc_oe, wave_rdy}, {4'h0, 3'b101});
    check(pin_fast, 9'h12d);
    rchk(`OFS_PIN_STATE, 32'h12d);
    wrap_up();
  end
endmodule // tb_usb_micro_port_pin_mux
